// file: rtl/sps_cfg.svh
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

// Register byte offsets
`define SPS_OFS_CTRL      4'h0
`define SPS_OFS_STATUS    4'h4
`define SPS_OFS_IRQ_STAT  4'h8
`define SPS_OFS_IRQ_MASK  4'hC

// Control fields and reset value
`define SPS_CTRL_SOFT_RST 0
`define SPS_CTRL_DRV_EN   1
`define SPS_CTRL_RST      32'h0000_0002

// Status fields
`define SPS_ST_STATE_LO   0
`define SPS_ST_HALF       8
`define SPS_ST_DIR        9
`define SPS_ST_OC_PULL    10
`define SPS_ST_HOT        11
`define SPS_ST_EN_PIN     12

// Interrupt event bits, mask reset value
`define SPS_EV_STEP       0
`define SPS_EV_OC         1
`define SPS_EV_HOT        2
`define SPS_EV_W          3
`define SPS_IRQ_MASK_RST  3'h0

// Pin vector bit positions
`define SPS_PIN_STEP      0
`define SPS_PIN_DIR       1
`define SPS_PIN_HALF      2
`define SPS_PIN_RST_N     3
`define SPS_PIN_OC        4
`define SPS_PIN_HOT       5
`define SPS_PIN_EN        6
`define SPS_PIN_W         7

`endif

// file: rtl/sps_pkg.sv
package sps_pkg;

  // One-hot sequencer states, state 1 in bit 0
  typedef enum logic [7:0] {
    SPS_S1 = 8'h01,
    SPS_S2 = 8'h02,
    SPS_S3 = 8'h04,
    SPS_S4 = 8'h08,
    SPS_S5 = 8'h10,
    SPS_S6 = 8'h20,
    SPS_S7 = 8'h40,
    SPS_S8 = 8'h80
  } sps_state_t;

  // Asynchronous pins from the controller and the analog side
  typedef struct packed {
    logic en_pin;             // Shared enable pin level
    logic thermal_hot;        // Temperature sensor trip, hysteresis included
    logic overcurrent_trip;   // High-side current comparator
    logic seq_reset_n;        // Sequencer reset, active low
    logic half_step;          // Step resolution: 1 half, 0 full
    logic rotation_direction; // 1 clockwise, 0 counterclockwise
    logic step_clk;           // Step clock
  } sps_pins_t;

  // Bridge controls
  typedef struct packed {
    logic en_a;
    logic ph_a;
    logic en_b;
    logic ph_b;
  } sps_bridge_t;

  // Avalon-MM request
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } sps_avm_req_t;

endpackage : sps_pkg

// file: rtl/sps_sequencer.sv
`timescale 1ns/1ns
`include "sps_cfg.svh"
// Function
// - Drive phase and enable for both bridges
// - Step clock rising edge advances, direction chooses
// - Power-up or reset places state 1
// - Resolution high: half step, all eight states
// - Half step clockwise: 1 through 8
// - Half step counterclockwise: 1,8,7,...,2
// - Low in odd state: normal full step
// - Normal: 1,3,5,7 or 1,7,5,3
// - Low in even state: wave drive
// - Wave: 2,4,6,8 or 8,6,4,2
// - Two phases in normal, one in wave
// - From state 1 half step: 2 or 8
// - Overcurrent trip flags a fault
// - Fault sinks enable pin, bridges off
// - Thermal trip switches outputs off
module sps_sequencer (
  input  wire logic                  ref_clk,     // 250 MHz clock
  input  wire logic                  srst,        // Sync reset, high
  input  wire sps_pkg::sps_pins_t    pins,        // Asynchronous pins
  input  wire sps_pkg::sps_avm_req_t avm_req,     // Avalon request
  output logic [31:0]                avm_readdata,    // Read data
  output logic                       avm_waitrequest, // Wait request
  output sps_pkg::sps_bridge_t       bridge,      // Bridge controls
  output logic                       en_pin_out,  // Enable pin drive
  output logic                       en_pin_oe,   // Enable sink on
  output logic                       irq          // Level interrupt
);
  import sps_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [`SPS_PIN_W-1:0] pin_raw;
  logic [`SPS_PIN_W-1:0] s1_q;
  logic [`SPS_PIN_W-1:0] s2_q;
  logic [`SPS_PIN_W-1:0] s3_q;
  logic [`SPS_PIN_W-1:0] flt_q;

  assign pin_raw = pins;

  // Three stages; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `SPS_PIN_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          s1_q[gi]  <= 1'b0;
          s2_q[gi]  <= 1'b0;
          s3_q[gi]  <= 1'b0;
          flt_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            flt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic step_f;
  logic dir_f;
  logic half_f;
  logic rst_n_f;
  logic oc_f;
  logic hot_f;
  logic en_f;

  assign step_f  = flt_q[`SPS_PIN_STEP];
  assign dir_f   = flt_q[`SPS_PIN_DIR];
  assign half_f  = flt_q[`SPS_PIN_HALF];
  assign rst_n_f = flt_q[`SPS_PIN_RST_N];
  assign oc_f    = flt_q[`SPS_PIN_OC];
  assign hot_f   = flt_q[`SPS_PIN_HOT];
  assign en_f    = flt_q[`SPS_PIN_EN];

  // ****************************************
  // Register bus
  // ****************************************
  logic [31:0] ctrl_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        acc_take;
  logic        wr_take;
  logic [31:0] status_w;
  logic [2:0]  events;
  sps_state_t  state_q;

  // Answer comes one cycle after the request is seen
  assign acc_take = (avm_req.read | avm_req.write) & wait_q;
  assign wr_take  = avm_req.write & ~wait_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~acc_take;
    end
  end

  // Status word assembled from live state
  always_comb begin
    status_w                  = 32'h0000_0000;
    status_w[7:0]             = state_q;
    status_w[`SPS_ST_HALF]    = half_f;
    status_w[`SPS_ST_DIR]     = dir_f;
    status_w[`SPS_ST_OC_PULL] = en_pin_oe;
    status_w[`SPS_ST_HOT]     = hot_f;
    status_w[`SPS_ST_EN_PIN]  = en_f;
  end

  // Read data latched while waitrequest is still high
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (acc_take && avm_req.read) begin
      unique case (avm_req.address)
        `SPS_OFS_CTRL:     rdata_q <= ctrl_q;
        `SPS_OFS_STATUS:   rdata_q <= status_w;
        `SPS_OFS_IRQ_STAT: rdata_q <= {29'h0000_0000, irq_stat_q};
        `SPS_OFS_IRQ_MASK: rdata_q <= {29'h0000_0000, irq_mask_q};
        default:           rdata_q <= 32'h0000_0000; // Unmapped reads 0
      endcase
    end
  end

  // Control and mask writes; unmapped writes are dropped
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q     <= `SPS_CTRL_RST;
      irq_mask_q <= `SPS_IRQ_MASK_RST;
    end else if (wr_take) begin
      if (avm_req.address == `SPS_OFS_CTRL) begin
        ctrl_q <= {30'h0000_0000, avm_req.writedata[1:0]};
      end
      if (avm_req.address == `SPS_OFS_IRQ_MASK) begin
        irq_mask_q <= avm_req.writedata[2:0];
      end
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_stat_q <= 3'h0;
    end else if (wr_take && avm_req.address == `SPS_OFS_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~avm_req.writedata[2:0]) | events;
    end else begin
      irq_stat_q <= irq_stat_q | events;
    end
  end

  // Interrupt output registered
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign avm_waitrequest = wait_q;
  assign avm_readdata    = rdata_q;

  // ****************************************
  // Phase sequencer
  // ****************************************
  logic       step_prev_q;
  logic       step_edge;
  logic       seq_hold;
  sps_state_t state_d;

  assign step_edge = step_f & ~step_prev_q;
  assign seq_hold  = ~rst_n_f | ctrl_q[`SPS_CTRL_SOFT_RST];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      step_prev_q <= 1'b0;
    end else begin
      step_prev_q <= step_f;
    end
  end

  // Rotation of the one-hot code gives the modulo-eight wrap.
  // Full step moves by two, so odd stays odd and even stays even:
  // the parity at the moment resolution goes low picks the drive.
  always_comb begin
    state_d = state_q;
    if (half_f && dir_f) begin
      state_d = sps_state_t'({state_q[6:0], state_q[7]});
    end else if (half_f) begin
      state_d = sps_state_t'({state_q[0], state_q[7:1]});
    end else if (dir_f) begin
      state_d = sps_state_t'({state_q[5:0], state_q[7:6]});
    end else begin
      state_d = sps_state_t'({state_q[1:0], state_q[7:2]});
    end
  end

  // Reset pin and soft reset override the step clock
  always_ff @(posedge ref_clk) begin
    if (srst || seq_hold) begin
      state_q <= SPS_S1;
    end else if (step_edge) begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Protection
  // ****************************************
  logic oc_pull_q;
  logic hot_prev_q;
  logic drive_ok;

  // Sink holds until the trip clears and the pin is seen low,
  // so the outside RC sets the disable time
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oc_pull_q <= 1'b0;
    end else if (oc_f) begin
      oc_pull_q <= 1'b1;
    end else if (!en_f) begin
      oc_pull_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      en_pin_oe  <= 1'b0;
      en_pin_out <= 1'b0;
    end else begin
      en_pin_oe  <= oc_f | oc_pull_q;
      en_pin_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hot_prev_q <= 1'b0;
    end else begin
      hot_prev_q <= hot_f;
    end
  end

  assign events[`SPS_EV_STEP] = step_edge & ~seq_hold;
  assign events[`SPS_EV_OC]   = oc_f & ~oc_pull_q;
  assign events[`SPS_EV_HOT]  = hot_f & ~hot_prev_q;

  // Sensor carries the hysteresis; logic only follows its level
  assign drive_ok = en_f & ~oc_f & ~oc_pull_q & ~hot_f
                  & ctrl_q[`SPS_CTRL_DRV_EN];

  // ****************************************
  // Bridge map
  // ****************************************
  // Odd states energise both windings, even states one only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bridge <= 4'h0;
    end else begin
      unique case (state_q)
        SPS_S1:  bridge <= {1'b1, 1'b1, 1'b1, 1'b1} & {4{drive_ok}};
        SPS_S2:  bridge <= {1'b0, 1'b0, 1'b1, 1'b1} & {4{drive_ok}};
        SPS_S3:  bridge <= {1'b1, 1'b0, 1'b1, 1'b1} & {4{drive_ok}};
        SPS_S4:  bridge <= {1'b1, 1'b0, 1'b0, 1'b0} & {4{drive_ok}};
        SPS_S5:  bridge <= {1'b1, 1'b0, 1'b1, 1'b0} & {4{drive_ok}};
        SPS_S6:  bridge <= {1'b0, 1'b0, 1'b1, 1'b0} & {4{drive_ok}};
        SPS_S7:  bridge <= {1'b1, 1'b1, 1'b1, 1'b0} & {4{drive_ok}};
        SPS_S8:  bridge <= {1'b1, 1'b1, 1'b0, 1'b0} & {4{drive_ok}};
        default: bridge <= 4'h0;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_reset_state1:
    assert property (seq_hold |=> state_q == SPS_S1)
    else $error("sequencer not in state 1 after reset");

  chk_half_cw:
    assert property (step_edge && !seq_hold && half_f && dir_f
      |=> state_q == {$past(state_q[6:0]), $past(state_q[7])})
    else $error("half step clockwise wrong");

  chk_half_ccw:
    assert property (step_edge && !seq_hold && half_f && !dir_f
      |=> state_q == {$past(state_q[0]), $past(state_q[7:1])})
    else $error("half step counterclockwise wrong");

  chk_start_half:
    assert property (state_q == SPS_S1 && step_edge && !seq_hold
      && half_f |=> state_q == ($past(dir_f) ? SPS_S2 : SPS_S8))
    else $error("first half step from state 1 wrong");

  chk_full_parity:
    assert property (step_edge && !seq_hold && !half_f
      |=> (state_q & 8'h55) == 8'h00 ? ($past(state_q) & 8'h55) == 8'h00
        : ($past(state_q) & 8'h55) != 8'h00)
    else $error("full step changed state parity");

  chk_full_cw:
    assert property (step_edge && !seq_hold && !half_f && dir_f
      |=> state_q == {$past(state_q[5:0]), $past(state_q[7:6])})
    else $error("full step clockwise wrong");

  chk_full_ccw:
    assert property (step_edge && !seq_hold && !half_f && !dir_f
      |=> state_q == {$past(state_q[1:0]), $past(state_q[7:2])})
    else $error("full step counterclockwise wrong");

  chk_no_step_hold:
    assert property (!step_edge && !seq_hold |=> $stable(state_q))
    else $error("state moved without a step edge");

  chk_phase_count:
    assert property (drive_ok |=> (bridge.en_a + bridge.en_b)
      == ((($past(state_q) & 8'h55) != 8'h00) ? 2'd2 : 2'd1))
    else $error("wrong number of energised windings");

  chk_oc_sink:
    assert property ($rose(oc_f) |=> en_pin_oe ##1 en_pin_oe)
    else $error("overcurrent did not sink enable");

  chk_oc_off:
    assert property (oc_f |=> !bridge.en_a && !bridge.en_b)
    else $error("bridges on during overcurrent");

  chk_hot_off:
    assert property (hot_f |=> !bridge.en_a && !bridge.en_b)
    else $error("bridges on while hot");

  chk_state_onehot:
    assert property ($onehot(state_q))
    else $error("state code not one-hot");

  // Sink must outlast the trip until the pin has really dropped
  chk_sink_hold:
    assert property (oc_pull_q && en_f |=> en_pin_oe)
    else $error("enable sink released before pin went low");

  chk_pin_off:
    assert property (!en_f |=> !bridge.en_a && !bridge.en_b)
    else $error("bridges on while enable pin low");

  chk_step_event:
    assert property (step_edge && !seq_hold |=> irq_stat_q[`SPS_EV_STEP])
    else $error("accepted step not recorded");

  cov_half_wrap:
    cover property (state_q == SPS_S8 && step_edge && half_f && dir_f);
  cov_wave_entry:
    cover property (state_q == SPS_S2 && !half_f ##1 step_edge);
  cov_oc_trip:
    cover property ($rose(en_pin_oe) ##[1:20] !en_pin_oe);

endmodule : sps_sequencer

// file: bench/sps_ctrl_model.sv
`timescale 1ns/1ns
// ************************************
// Step controller seen from the pins
// ************************************
module sps_ctrl_model (
  input  wire logic ref_clk,   // Clock
  input  wire logic srst,      // Reset, high
  input  wire logic step_go,   // Start one step pulse
  input  wire logic dir_set,   // Wanted direction
  input  wire logic half_set,  // Wanted resolution
  input  wire logic rst_set,   // Hold sequencer in reset
  output logic      step_clk,  // Step clock pin
  output logic      dir_pin,   // Direction pin
  output logic      half_pin,  // Resolution pin
  output logic      rst_n_pin, // Sequencer reset pin
  output logic      busy       // Pulse in progress
);
  logic [3:0] cnt_q;

  // High 3 cycles, low 9: both beat the pin filter
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= 4'h0;
    end else if (step_go) begin
      cnt_q <= 4'hC;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // Every pin driven firmly, never left floating
  always_ff @(posedge ref_clk) begin
    step_clk  <= ~srst & (cnt_q > 4'h9);
    dir_pin   <= dir_set;
    half_pin  <= half_set;
    rst_n_pin <= ~rst_set;
  end

  assign busy = (cnt_q != 4'h0);
endmodule : sps_ctrl_model

// file: bench/tb.sv
`timescale 1ns/1ns
`include "sps_cfg.svh"
// ************************************
// Bench for the phase sequencer
// ************************************
module tb;
  import sps_pkg::*;
  logic         ref_clk, srst, go, dsel, hsel, rsel, oc, hot;
  logic         stp, dp, hp, rnp, busy, en_oe, en_out, irq, wreq;
  logic [31:0]  rdata, d;
  sps_avm_req_t req;
  sps_bridge_t  br;
  sps_pins_t    pins;
  int           n_mismatch, tests_run, st;

  // Pull-up on the enable line; the sink pulls it low
  assign pins = '{en_pin: en_oe ? en_out : 1'b1, thermal_hot: hot,
                  overcurrent_trip: oc, seq_reset_n: rnp, half_step: hp,
                  rotation_direction: dp, step_clk: stp};

  sps_sequencer dut (.ref_clk(ref_clk), .srst(srst), .pins(pins),
    .avm_req(req), .avm_readdata(rdata), .avm_waitrequest(wreq),
    .bridge(br), .en_pin_out(en_out), .en_pin_oe(en_oe), .irq(irq));
  sps_ctrl_model ctl (.ref_clk(ref_clk), .srst(srst), .step_go(go),
    .dir_set(dsel), .half_set(hsel), .rst_set(rsel), .step_clk(stp),
    .dir_pin(dp), .half_pin(hp), .rst_n_pin(rnp), .busy(busy));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ************************************
  // Shared tasks
  // ************************************
  task automatic wrap_up;
    $display("counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t value %h exp %h", $time, g, e);
    end
  endtask : cmp_reg

  task automatic cmp_br(input logic [3:0] g, input logic [3:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t bridge %h exp %h", $time, g, e);
    end
  endtask : cmp_br

  // Hold the request until waitrequest is sampled low
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    req.address <= a;
    req.read    <= 1'b1;
    do @(posedge ref_clk); while (wreq !== 1'b0);
    v = rdata;
    req.read <= 1'b0;
  endtask : bus_rd

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    req.address   <= a;
    req.writedata <= v;
    req.write     <= 1'b1;
    do @(posedge ref_clk); while (wreq !== 1'b0);
    req.write <= 1'b0;
  endtask : bus_wr

  // En_a, ph_a, en_b, ph_b for each state
  function automatic logic [3:0] br_of(input int s);
    case (s)
      1: return 4'hF;
      2: return 4'h3;
      3: return 4'hB;
      4: return 4'h8;
      5: return 4'hA;
      6: return 4'h2;
      7: return 4'hE;
      default: return 4'hC;
    endcase
  endfunction : br_of

  task automatic check(input int s);
    bus_rd(`SPS_OFS_STATUS, d);
    cmp_reg({24'h0, d[7:0]}, 32'h1 << (s - 1));
    cmp_br(br, br_of(s));
  endtask : check

  // Extra edge first: busy is sampled only after it has risen
  task automatic pulse;
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    while (busy) @(posedge ref_clk);
  endtask : pulse

  // Inc is the state stride modulo eight
  task automatic run(input int n, input int inc);
    for (int i = 0; i < n; i++) begin
      pulse;
      st = (st - 1 + inc) % 8 + 1;
      check(st);
    end
  endtask : run

  task automatic set_mode(input logic h, input logic dr);
    hsel <= h;
    dsel <= dr;
    repeat (6) @(posedge ref_clk);
  endtask : set_mode

  task automatic seq_rst;
    rsel <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rsel <= 1'b0;
    repeat (6) @(posedge ref_clk);
    st = 1;
    check(1);
  endtask : seq_rst

  // ************************************
  // Scenarios
  // ************************************
  task automatic t_reset;
    check(1);
    bus_rd(`SPS_OFS_CTRL, d);
    cmp_reg(d, `SPS_CTRL_RST);
    bus_rd(`SPS_OFS_IRQ_MASK, d);
    cmp_reg(d, 32'h0);
    bus_rd(4'h6, d);
    cmp_reg(d, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // Drive enable off blanks the bridges; soft reset refuses steps
  task automatic t_ctrl;
    bus_wr(`SPS_OFS_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk);
    cmp_br(br, 4'h0);
    bus_wr(`SPS_OFS_CTRL, 32'h3);
    pulse;
    st = 1;
    check(1);
    bus_wr(`SPS_OFS_CTRL, `SPS_CTRL_RST);
    bus_rd(`SPS_OFS_CTRL, d);
    cmp_reg(d, `SPS_CTRL_RST);
    $display("test control done");
  endtask : t_ctrl

  task automatic t_half(input logic dr);
    set_mode(1'b1, dr);
    seq_rst;
    run(8, dr ? 1 : 7);
    $display("test half step done");
  endtask : t_half

  task automatic t_normal;
    set_mode(1'b0, 1'b1);
    seq_rst;
    run(4, 2);
    set_mode(1'b0, 1'b0);
    run(2, 6);
    $display("test normal drive done");
  endtask : t_normal

  task automatic t_wave;
    set_mode(1'b1, 1'b1);
    seq_rst;
    run(1, 1);
    set_mode(1'b0, 1'b1);
    run(4, 2);
    set_mode(1'b0, 1'b0);
    run(2, 6);
    $display("test wave drive done");
  endtask : t_wave

  task automatic t_fault;
    seq_rst;
    bus_wr(`SPS_OFS_IRQ_STAT, 32'h7);
    bus_wr(`SPS_OFS_IRQ_MASK, 32'h2);
    oc <= 1'b1;
    repeat (8) @(posedge ref_clk);
    cmp_reg({31'h0, en_oe}, 32'h1);
    cmp_reg({31'h0, en_out}, 32'h0);
    cmp_br(br, 4'h0);
    bus_rd(`SPS_OFS_IRQ_STAT, d);
    cmp_reg(d, 32'h2);
    cmp_reg({31'h0, irq}, 32'h1);
    bus_rd(`SPS_OFS_STATUS, d);
    cmp_reg(d & 32'h1F00, 32'h1 << `SPS_ST_OC_PULL);
    oc <= 1'b0;
    repeat (12) @(posedge ref_clk);
    cmp_reg({31'h0, en_oe}, 32'h0);
    cmp_br(br, 4'hF);
    bus_wr(`SPS_OFS_IRQ_STAT, 32'h2);
    repeat (3) @(posedge ref_clk);
    cmp_reg({31'h0, irq}, 32'h0);
    hot <= 1'b1;
    repeat (8) @(posedge ref_clk);
    cmp_br(br, 4'h0);
    cmp_reg({31'h0, irq}, 32'h0);
    bus_rd(`SPS_OFS_STATUS, d);
    cmp_reg(d & 32'h1F00, (32'h1 << `SPS_ST_HOT)
      | (32'h1 << `SPS_ST_EN_PIN));
    bus_wr(`SPS_OFS_IRQ_MASK, 32'h4);
    repeat (3) @(posedge ref_clk);
    cmp_reg({31'h0, irq}, 32'h1);
    hot <= 1'b0;
    repeat (8) @(posedge ref_clk);
    cmp_br(br, 4'hF);
    $display("test faults done");
  endtask : t_fault

  initial begin
    srst = 1'b1;
    {go, dsel, hsel, rsel, oc, hot} = 6'h0;
    req = '0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    t_reset;
    t_half(1'b1);
    t_half(1'b0);
    t_normal;
    t_wave;
    t_ctrl;
    t_fault;
    wrap_up;
  end

  // About 800 cycles expected; a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    wrap_up;
  end
endmodule : tb
